/* rtl/scsm_pkg.sv */
// shared constants and types for the serial controller spi master
package scsm_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CLK_MHZ       = 1000 / CLK_PERIOD_NS;
    localparam int unsigned REF_MHZ       = 12;
    localparam int unsigned MAX_RATE_MBPS = 6;

    localparam logic [4:0] REF_ACC_INC = 5'(REF_MHZ);
    localparam logic [4:0] REF_ACC_MOD = 5'(CLK_MHZ);

    localparam logic [1:0] MODE_SPI     = 2'h2;
    localparam int unsigned FIFO_DEPTH  = 4;
    localparam int unsigned CHAR_BITS   = 8;
    localparam int unsigned EXP_W       = 4;
    localparam int unsigned LIN_W       = 8;
    localparam int unsigned PER_W       = 24;

    localparam logic [2:0] IRQ_TXIDLE = 3'h1;
    localparam logic [2:0] IRQ_TXFREE = 3'h2;
    localparam logic [2:0] IRQ_RXVAL  = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_XFER = 2'b10
    } scsm_state_t;

    typedef struct packed {
        logic pol;
        logic pha;
        logic ord;
    } scsm_frame_cfg_t;

endpackage

/* rtl/scsm_fifo.sv */
// small valid/ready character fifo
`timescale 1ns/1ps
`default_nettype none

module scsm_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 4
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
    localparam int unsigned CW = $clog2(D + 1);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [CW-1:0] cnt_r;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_r != CW'(D));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                mem_r[wr_r] <= in_data_i;
                wr_r        <= (wr_r == AW'(D - 1)) ? '0 : wr_r + AW'(1);
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + AW'(1);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + CW'(1);
            end else if (pop && !push) begin
                cnt_r <= cnt_r - CW'(1);
            end
        end
    end
endmodule

`default_nettype wire

/* rtl/scsm_master.sv */
// spi master engine with rate generator, fifos and event outputs
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - software picks edge or level events; the block honours that choice
// - master starts frames only with mode 2, master select 1 and ack bit 1
// - sclk rate is 12 MHz over (linear+1) times two to the exponent; linear 0 with exponent 0 leaves sclk at its idle level
// - all polarity, phase and order combinations shape each 8-bit frame
// - order 0 shifts msb first, order 1 lsb first, same timing
// - mosi is driven push-pull, shifting out while receiving
// - miso is sampled as input; slave drives it in step with sclk
// - sclk is driven push-pull and paces both data lines
// - transmit and receive characters pass through four-deep fifos
module scsm_master
    import scsm_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic [1:0]           controller_mode_select_i,
    input  wire logic                 master_select_bit_i,
    input  wire logic                 twowire_ack_bit_i,
    input  wire logic [EXP_W-1:0]     rate_exponent_i,
    input  wire logic [LIN_W-1:0]     rate_linear_i,
    input  wire logic                 clock_polarity_bit_i,
    input  wire logic                 clock_phase_bit_i,
    input  wire logic                 bit_order_bit_i,
    input  wire logic                 interrupt_trigger_mode_i,
    input  wire logic [2:0]           second_level_int_enable_i,
    input  wire logic [CHAR_BITS-1:0] tx_data_i,
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    output logic [CHAR_BITS-1:0]      rx_data_o,
    output logic                      rx_valid_o,
    input  wire logic                 rx_ready_i,
    input  wire logic                 rx_ovf_clr_i,
    output logic                      rx_ovf_o,
    output logic                      tx_idle_o,
    output logic                      tx_free_o,
    output logic                      irq_o,
    output logic                      sclk_o,
    output logic                      mosi_o,
    input  wire logic                 miso_i
);

    ////////////////////////////////////////////////////////////////////////////
    // fifos

    logic [CHAR_BITS-1:0] txf_data;
    logic                 txf_valid;
    logic                 txf_pop;
    logic                 rxf_ready;
    logic                 rx_push_r;
    logic [CHAR_BITS-1:0] rx_byte_r;

    scsm_fifo #(.W(CHAR_BITS), .D(DEPTH)) u_txf (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (txf_data),
        .out_valid_o (txf_valid),
        .out_ready_i (txf_pop)
    );

    scsm_fifo #(.W(CHAR_BITS), .D(DEPTH)) u_rxf (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_data_i   (rx_byte_r),
        .in_valid_i  (rx_push_r),
        .in_ready_o  (rxf_ready),
        .out_data_o  (rx_data_o),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    scsm_state_t          state_r,    state_nxt;
    logic [4:0]           acc_r,      acc_nxt;
    logic [PER_W-1:0]     cnt_r,      cnt_nxt;
    logic                 sclk_r,     sclk_nxt;
    logic                 mosi_r,     mosi_nxt;
    logic [2:0]           idx_r,      idx_nxt;
    logic [CHAR_BITS-1:0] tx_byte_r,  tx_byte_nxt;
    logic [CHAR_BITS-1:0] rx_byte_nxt;
    logic                 rx_push_nxt;
    scsm_frame_cfg_t      cfg_r,      cfg_nxt;
    logic                 ovf_r,      ovf_nxt;
    logic [2:0]           lvl_r,      lvl_nxt;
    logic                 irq_r,      irq_nxt;
    logic                 idle_r,     idle_nxt;
    logic                 free_r,     free_nxt;

    logic                 enabled;
    logic                 ref_tick;
    logic [PER_W-1:0]     period;
    logic [PER_W-1:0]     half;
    logic                 lead;
    logic                 trail;
    logic [2:0]           ev;

    function automatic logic pick_bit(input logic [CHAR_BITS-1:0] b, input logic [2:0] i,
                                      input logic ord);
        pick_bit = ord ? b[i] : b[3'h7 - i];
    endfunction

    assign enabled = (controller_mode_select_i == MODE_SPI) && master_select_bit_i
                     && twowire_ack_bit_i;
    assign period  = PER_W'(({16'h0, rate_linear_i} + 24'h1) << rate_exponent_i);
    assign half    = (period > 24'h1) ? (period >> 1) : 24'h1;
    assign txf_pop = (state_r == ST_IDLE) && enabled && txf_valid;

    always_comb begin
        state_nxt   = state_r;
        acc_nxt     = acc_r;
        cnt_nxt     = cnt_r;
        sclk_nxt    = sclk_r;
        mosi_nxt    = mosi_r;
        idx_nxt     = idx_r;
        tx_byte_nxt = tx_byte_r;
        rx_byte_nxt = rx_byte_r;
        rx_push_nxt = 1'b0;
        cfg_nxt     = cfg_r;
        ref_tick    = 1'b0;
        lead        = 1'b0;
        trail       = 1'b0;
        // 12 MHz tick from the 20 MHz clock by fractional accumulation
        if (acc_r + REF_ACC_INC >= REF_ACC_MOD) begin
            acc_nxt  = acc_r + REF_ACC_INC - REF_ACC_MOD;
            ref_tick = 1'b1;
        end else begin
            acc_nxt = acc_r + REF_ACC_INC;
        end
        case (state_r)
            ST_IDLE: begin
                sclk_nxt = clock_polarity_bit_i;
                cnt_nxt  = '0;
                if (txf_pop) begin
                    cfg_nxt     = '{pol: clock_polarity_bit_i, pha: clock_phase_bit_i,
                                    ord: bit_order_bit_i};
                    tx_byte_nxt = txf_data;
                    idx_nxt     = 3'h0;
                    mosi_nxt    = pick_bit(txf_data, 3'h0, bit_order_bit_i);
                    state_nxt   = ST_XFER;
                end
            end
            ST_XFER: begin
                if (ref_tick) begin
                    if (cnt_r == half - 24'h1) begin
                        lead = 1'b1;
                    end
                    if (cnt_r >= period - 24'h1) begin
                        trail   = 1'b1;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 24'h1;
                    end
                end
                if (lead) begin
                    sclk_nxt = ~cfg_r.pol;
                    if (!cfg_r.pha) begin
                        rx_byte_nxt[cfg_r.ord ? idx_r : 3'h7 - idx_r] = miso_i;
                    end else if (idx_r != 3'h0) begin
                        mosi_nxt = pick_bit(tx_byte_r, idx_r, cfg_r.ord);
                    end
                end
                if (trail) begin
                    sclk_nxt = cfg_r.pol;
                    if (cfg_r.pha) begin
                        rx_byte_nxt[cfg_r.ord ? idx_r : 3'h7 - idx_r] = miso_i;
                    end
                    if (idx_r == 3'h7) begin
                        rx_push_nxt = 1'b1;
                        state_nxt   = ST_IDLE;
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                        if (!cfg_r.pha) begin
                            mosi_nxt = pick_bit(tx_byte_r, idx_r + 3'h1, cfg_r.ord);
                        end
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and events

    always_comb begin
        ovf_nxt  = ovf_r;
        if (rx_ovf_clr_i) begin
            ovf_nxt = 1'b0;
        end
        if (rx_push_r && !rxf_ready) begin
            ovf_nxt = 1'b1;
        end
        idle_nxt = !txf_valid && (state_r == ST_IDLE);
        free_nxt = tx_ready_o;
        lvl_nxt  = {rx_valid_o, free_r, idle_r};
        ev       = interrupt_trigger_mode_i ? (lvl_nxt & ~lvl_r) : lvl_nxt;
        irq_nxt  = |(ev & second_level_int_enable_i);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r   <= ST_IDLE;
            acc_r     <= '0;
            cnt_r     <= '0;
            sclk_r    <= 1'b0;
            mosi_r    <= 1'b0;
            idx_r     <= '0;
            tx_byte_r <= '0;
            rx_byte_r <= '0;
            rx_push_r <= 1'b0;
            cfg_r     <= '0;
            ovf_r     <= 1'b0;
            lvl_r     <= 3'h3;
            irq_r     <= 1'b0;
            idle_r    <= 1'b1;
            free_r    <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            acc_r     <= acc_nxt;
            cnt_r     <= cnt_nxt;
            sclk_r    <= sclk_nxt;
            mosi_r    <= mosi_nxt;
            idx_r     <= idx_nxt;
            tx_byte_r <= tx_byte_nxt;
            rx_byte_r <= rx_byte_nxt;
            rx_push_r <= rx_push_nxt;
            cfg_r     <= cfg_nxt;
            ovf_r     <= ovf_nxt;
            lvl_r     <= lvl_nxt;
            irq_r     <= irq_nxt;
            idle_r    <= idle_nxt;
            free_r    <= free_nxt;
        end
    end

    assign sclk_o    = sclk_r;
    assign mosi_o    = mosi_r;
    assign rx_ovf_o  = ovf_r;
    assign tx_idle_o = idle_r;
    assign tx_free_o = free_r;
    assign irq_o     = irq_r;

endmodule

`default_nettype wire

/* dv/scsm_master_checker.sv */
// concurrent checks on the spi master ports
`timescale 1ns/1ps
`default_nettype none
module scsm_master_checker
    import scsm_pkg::*;
(
    input wire logic             mclk_i,
    input wire logic             rst_i,
    input wire logic [1:0]       controller_mode_select_i,
    input wire logic             master_select_bit_i,
    input wire logic             twowire_ack_bit_i,
    input wire logic [EXP_W-1:0] rate_exponent_i,
    input wire logic [LIN_W-1:0] rate_linear_i,
    input wire logic             clock_polarity_bit_i,
    input wire logic             interrupt_trigger_mode_i,
    input wire logic [2:0]       second_level_int_enable_i,
    input wire logic             tx_ready_o,
    input wire logic [7:0]       rx_data_o,
    input wire logic             rx_valid_o,
    input wire logic             rx_ready_i,
    input wire logic             rx_ovf_clr_i,
    input wire logic             rx_ovf_o,
    input wire logic             tx_idle_o,
    input wire logic             tx_free_o,
    input wire logic             irq_o,
    input wire logic             sclk_o
);
    logic              en;
    logic              sclk_q_r;
    logic [15:0]       hc_r;
    logic [15:0]       hc_nxt;
    logic [PER_W-1:0]  half;
    assign en = (controller_mode_select_i == MODE_SPI) && master_select_bit_i && twowire_ack_bit_i;
    always_comb begin
        half = ((PER_W'(rate_linear_i) + 24'h1) << rate_exponent_i) >> 1;
        hc_nxt = (sclk_o != sclk_q_r) ? 16'h0 : ((hc_r == 16'hffff) ? hc_r : hc_r + 16'h1);
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'b0;
            hc_r     <= 16'hffff;
        end else begin
            sclk_q_r <= sclk_o;
            hc_r     <= hc_nxt;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_edge;
        $changed(sclk_o) && !tx_idle_o && (half < 24'h8000);
    endsequence
    sequence s_stall;
        rx_valid_o && !rx_ready_i;
    endsequence
    chk_reset_outputs: assert property (disable iff (1'b0) rst_i |=>
        !sclk_o && !rx_valid_o && tx_ready_o && !rx_ovf_o && !irq_o) else $error("reset values");
    chk_disabled_no_frame: assert property (!en && tx_idle_o && $past(tx_idle_o)
        && $past(tx_idle_o, 2) |=> !$rose(rx_valid_o)) else $error("frame while disabled");
    chk_sclk_idle_pol: assert property (tx_idle_o && $past(tx_idle_o) && $past(tx_idle_o, 2)
        && !$past(rst_i) && $stable(clock_polarity_bit_i) |-> sclk_o == clock_polarity_bit_i)
        else $error("idle clock level");
    chk_half_period: assert property (s_edge |-> PER_W'(hc_r) + 24'h2 >= half)
        else $error("clock half period short");
    chk_ovf_sticky: assert property (rx_ovf_o && !rx_ovf_clr_i |=> rx_ovf_o)
        else $error("overflow lost");
    chk_ovf_clear: assert property (rx_ovf_clr_i && !rx_valid_o |=> !rx_ovf_o)
        else $error("overflow not cleared");
    chk_full_no_free: assert property ($fell(tx_ready_o) |=> !tx_free_o)
        else $error("free while full");
    chk_rx_hold: assert property (s_stall |=> rx_valid_o && $stable(rx_data_o))
        else $error("rx word moved");
    chk_disabled_hold: assert property (!en && !tx_ready_o |=> !tx_ready_o)
        else $error("fifo drained while disabled");
    chk_level_irq: assert property (!interrupt_trigger_mode_i && second_level_int_enable_i[0]
        && tx_idle_o |-> ##[0:2] irq_o) else $error("level event missing");
endmodule
bind scsm_master scsm_master_checker chk (.mclk_i, .rst_i, .controller_mode_select_i,
    .master_select_bit_i, .twowire_ack_bit_i, .rate_exponent_i, .rate_linear_i,
    .clock_polarity_bit_i, .interrupt_trigger_mode_i, .second_level_int_enable_i, .tx_ready_o,
    .rx_data_o, .rx_valid_o, .rx_ready_i, .rx_ovf_clr_i, .rx_ovf_o, .tx_idle_o, .tx_free_o,
    .irq_o, .sclk_o);
`default_nettype wire

/* dv/scsm_slave_model.sv */
// behavioural spi slave facing the master
`timescale 1ns/1ps
`default_nettype none
module scsm_slave_model (
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic       pol_i,
    input  wire logic       pha_i,
    input  wire logic       ord_i,
    input  wire logic       load_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic [7:0]      rx_o
);
    int n = 0;
    int k = 0;
    initial miso_o = 1'b0;
    initial rx_o = 8'h00;
    function automatic logic bit_at(input int j);
        return ord_i ? tx_i[j] : tx_i[7-j];
    endfunction
    always @(posedge load_i) begin
        k = 0;
        n = pha_i ? 0 : 1;
        if (!pha_i) miso_o = bit_at(0);
    end
    always @(sclk_i) begin
        if ((sclk_i != pol_i) != pha_i) begin
            rx_o = ord_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
            k = k + 1;
            if (k == 8) begin
                miso_o = ~miso_o;
                k = 0;
                if (pha_i) n = 0;
            end
        end else if (n < 8) begin
            miso_o = bit_at(n);
            n = n + 1;
        end
    end
endmodule
`default_nettype wire

/* dv/test_scsm_master.sv */
// self-checking bench for the spi master
`timescale 1ns/1ps
`default_nettype none
module test_scsm_master import scsm_pkg::*;;
    logic mclk_i = 1'b0;
    logic rst_i, master_select_bit_i, twowire_ack_bit_i, interrupt_trigger_mode_i, ld;
    logic clock_polarity_bit_i, clock_phase_bit_i, bit_order_bit_i, tx_valid_i, rx_ready_i;
    logic rx_ovf_clr_i, tx_ready_o, rx_valid_o, rx_ovf_o, tx_idle_o, tx_free_o, irq_o;
    logic sclk_o, mosi_o, miso_i;
    logic [1:0]       controller_mode_select_i;
    logic [2:0]       second_level_int_enable_i;
    logic [EXP_W-1:0] rate_exponent_i;
    logic [LIN_W-1:0] rate_linear_i;
    logic [7:0]       tx_data_i, rx_data_o, s_tx, s_rx;
    int               mismatches = 0, tests_run = 0, i, n, hi;
    always #25 mclk_i = ~mclk_i;
    scsm_master #(.DEPTH(4)) dut (.mclk_i, .rst_i, .controller_mode_select_i,
        .master_select_bit_i, .twowire_ack_bit_i, .rate_exponent_i, .rate_linear_i,
        .clock_polarity_bit_i, .clock_phase_bit_i, .bit_order_bit_i, .interrupt_trigger_mode_i,
        .second_level_int_enable_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
        .rx_valid_o, .rx_ready_i, .rx_ovf_clr_i, .rx_ovf_o, .tx_idle_o, .tx_free_o, .irq_o,
        .sclk_o, .mosi_o, .miso_i);
    scsm_slave_model slave (.sclk_i(sclk_o), .mosi_i(mosi_o), .pol_i(clock_polarity_bit_i),
        .pha_i(clock_phase_bit_i), .ord_i(bit_order_bit_i), .load_i(ld), .tx_i(s_tx),
        .miso_o(miso_i), .rx_o(s_rx));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tmo(input string m);
        mismatches++;
        $display("mismatch at %0t: timeout in %s", $time, m);
        final_report();
    endtask
    task automatic push(input logic [7:0] b);
        logic acc;
        tx_data_i <= b;
        tx_valid_i <= 1'b1;
        n = 0;
        do begin
            @(negedge mclk_i);
            acc = (tx_ready_o === 1'b1);
            @(posedge mclk_i);
            n++;
        end while (!acc && n < 3000);
        if (!acc) tmo("push");
        tx_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic pop(input logic [7:0] e);
        n = 0;
        @(negedge mclk_i);
        while (rx_valid_o !== 1'b1 && n < 3000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 3000) tmo("pop");
        chk(rx_data_o, e, "rx word");
        @(posedge mclk_i);
        rx_ready_i <= 1'b1;
        @(posedge mclk_i);
        rx_ready_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wait_idle();
        repeat (4) @(posedge mclk_i);
        n = 0;
        @(negedge mclk_i);
        while (tx_idle_o !== 1'b1 && n < 3000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 3000) tmo("idle");
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic cfg(input logic p, input logic h, input logic o, input logic [7:0] b);
        clock_polarity_bit_i <= p;
        clock_phase_bit_i <= h;
        bit_order_bit_i <= o;
        s_tx <= b;
        repeat (4) @(posedge mclk_i);
        ld <= 1'b1;
        @(posedge mclk_i);
        ld <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, master_select_bit_i, twowire_ack_bit_i} = 3'h7;
        {interrupt_trigger_mode_i, ld, tx_valid_i, rx_ready_i, rx_ovf_clr_i} = 5'h00;
        {clock_polarity_bit_i, clock_phase_bit_i, bit_order_bit_i} = 3'h0;
        controller_mode_select_i = MODE_SPI;
        second_level_int_enable_i = 3'h1;
        rate_exponent_i = 4'h0;
        rate_linear_i = 8'h01;
        tx_data_i = 8'h00;
        s_tx = 8'h00;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        chk({6'h0, tx_ready_o, rx_valid_o}, 8'h02, "reset");
        for (i = 0; i < 8; i++) begin
            cfg(i[0], i[1], i[2], 8'hc1 + 8'(i));
            push(8'h2d ^ 8'(i));
            pop(8'hc1 + 8'(i));
            wait_idle();
            chk(s_rx, 8'h2d ^ 8'(i), "mosi word");
            chk({7'h0, sclk_o}, {7'h0, i[0]}, "idle clock");
        end
        rate_exponent_i <= 4'h2;
        rate_linear_i <= 8'h02;
        cfg(1'b0, 1'b0, 1'b0, 8'ha5);
        push(8'h0f);
        hi = 0;
        n = 0;
        while (rx_valid_o !== 1'b1 && n < 3000) begin
            @(negedge mclk_i);
            n++;
            if (sclk_o === 1'b1) hi++;
        end
        if (n >= 3000) tmo("rate");
        chk(8'(hi), 8'd80, "high cycles");
        pop(8'ha5);
        wait_idle();
        rate_exponent_i <= 4'h0;
        rate_linear_i <= 8'h01;
        twowire_ack_bit_i <= 1'b0;
        cfg(1'b0, 1'b1, 1'b1, 8'h4b);
        for (i = 0; i < 4; i++) push(8'h10 + 8'(i));
        for (i = 0; i < 3; i++) begin
            controller_mode_select_i <= (i == 0) ? 2'h1 : MODE_SPI;
            master_select_bit_i <= (i != 1);
            twowire_ack_bit_i <= (i != 2);
            repeat (60) @(posedge mclk_i);
            chk({5'h0, tx_free_o, rx_valid_o, tx_ready_o}, 8'h00, "disabled");
        end
        twowire_ack_bit_i <= 1'b1;
        push(8'h77);
        wait_idle();
        chk({6'h0, rx_ovf_o, irq_o}, 8'h03, "overflow");
        for (i = 0; i < 4; i++) pop(8'h4b);
        rx_ovf_clr_i <= 1'b1;
        @(posedge mclk_i);
        rx_ovf_clr_i <= 1'b0;
        @(posedge mclk_i);
        chk({6'h0, rx_ovf_o, rx_valid_o}, 8'h00, "drained");
        interrupt_trigger_mode_i <= 1'b1;
        second_level_int_enable_i <= 3'h4;
        repeat (3) @(posedge mclk_i);
        chk({7'h0, irq_o}, 8'h00, "edge quiet");
        push(8'h5a);
        hi = 0;
        for (n = 0; n < 200; n++) begin
            @(negedge mclk_i);
            if (irq_o === 1'b1) hi++;
        end
        chk(8'(hi), 8'd1, "edge pulses");
        pop(8'h4b);
        chk(s_rx, 8'h5a, "edge mosi word");
        final_report();
    end
endmodule
`default_nettype wire
